/* File: core/switch_reset_map.vh */
// switch reset and mode front end: constants
// assumes inclusion by the files under core/
`ifndef SWITCH_RESET_MAP_VH
`define SWITCH_RESET_MAP_VH

`define MODE_W 4
`define MODE_SINGLE 4'h0
`define MODE_SINGLE_EE 4'h1
`define MODE_SINGLE_JUMP0 4'h2
`define MODE_SINGLE_JUMP1 4'h3
`define MODE_RSVD_LO 4'h4
`define MODE_RSVD_HI 4'h7
`define MODE_LOWLAT 4'h8
`define MODE_LOWLAT_EE 4'h9
`define MODE_MULTI_UNATT 4'hA
`define MODE_MULTI_UNATT_I2C 4'hB
`define MODE_MULTI_UNATT_EE 4'hC
`define MODE_MULTI_DIS 4'hD
`define MODE_MULTI_DIS_I2C 4'hE
`define MODE_MULTI_DIS_EE 4'hF
`define JUMP_ENTRY0 2'h0
`define JUMP_ENTRY1 2'h1

`define PH_W 2
`define PH_RESET 2'h0
`define PH_HALT 2'h1
`define PH_RUN 2'h2

`endif

/* File: core/pin_sync3.v */
// three-stage synchroniser for pin inputs with agreement filter
// assumes the pins are asynchronous to clk_sys
`timescale 1ns/1ps
`include "switch_reset_map.vh"
module pin_sync3 #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input wire clk_sys,
  input wire resetn,
  input wire [W-1:0] pin,
  output wire [W-1:0] level
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  reg [W-1:0] lvl_q;

  // first stage feeds only the second
  always @(posedge clk_sys) begin
    if (!resetn) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      lvl_q <= INIT;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        lvl_q <= s3_q;
      end
    end
  end

  assign level = lvl_q;
endmodule

/* File: core/switch_reset_mode.v */
// switch fundamental reset, reset-halt and static mode decode
// assumes an smbus block elsewhere owns the control register and sends set and clear pulses for the halt bit kept here
//
// Function
// - while the fundamental reset pin is low the phase machine returns to reset and the halt level and mode follow the pins.
// - reset_halt sampled during reset holds the switch in quasi-reset with both smbus ports on.
// - in quasi-reset the smbus slave keeps register access enabled for configuration.
// - quasi-reset ends when the smbus master clears the halt bit of switch_control_reg.
// - code 0x0 is single partition and 0x1 single partition with eeprom init.
// - codes 0x2 and 0x3 are single partition with eeprom init from jump entry 0 and 1.
// - codes 0x4 to 0x7 are reserved and select no defined mode.
// - code 0x8 is reduced-latency single partition and 0x9 adds eeprom init.
// - codes 0xA to 0xF are multi partition, unattached or disabled, with i2c reset or eeprom.
`timescale 1ns/1ps
`include "switch_reset_map.vh"
module switch_reset_mode (
  input wire clk_sys,
  input wire resetn,
  input wire fundamental_reset_n,
  input wire reset_halt,
  input wire [3:0] switch_mode_select,
  input wire halt_bit_set,
  input wire halt_bit_clear,
  output reg core_reset_n,
  output reg quasi_reset,
  output reg smbus_master_en,
  output reg smbus_slave_en,
  output reg smbus_reg_access_en,
  output reg halt_bit,
  output reg [3:0] mode_q,
  output reg mode_valid,
  output reg multi_partition,
  output reg eeprom_init,
  output reg [1:0] eeprom_jump,
  output reg jump_valid,
  output reg reduced_latency,
  output reg ports_disabled,
  output reg i2c_reset
);
  // ************************************************************
  // pin synchronisers
  // ************************************************************
  wire perst_n_s;
  wire halt_s;
  wire [3:0] mode_s;

  // start asserted so the switch sits in reset until the pin is seen high
  pin_sync3 #(.W(6), .INIT(6'h00)) u_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .pin({fundamental_reset_n, reset_halt, switch_mode_select}),
    .level({perst_n_s, halt_s, mode_s})
  );

  // ************************************************************
  // mode decode
  // ************************************************************
  function is_reserved;
    input [3:0] m;
    begin
      is_reserved = (m >= `MODE_RSVD_LO) && (m <= `MODE_RSVD_HI);
    end
  endfunction

  // ************************************************************
  // reset phase machine
  // ************************************************************
  reg [1:0] phase_q;
  reg [1:0] phase_d;
  reg halt_req_q;
  reg [3:0] mode_cap_q;

  always @* begin
    phase_d = phase_q;
    case (phase_q)
      `PH_RESET: begin
        if (perst_n_s) begin
          phase_d = halt_req_q ? `PH_HALT : `PH_RUN;
        end
      end
      `PH_HALT: begin
        if (!halt_bit) begin
          phase_d = `PH_RUN;
        end
      end
      `PH_RUN: begin
        phase_d = `PH_RUN;
      end
      default: begin
        phase_d = `PH_RESET;
      end
    endcase
    if (!perst_n_s) begin
      phase_d = `PH_RESET;
    end
  end

  always @(posedge clk_sys) begin
    if (!resetn) begin
      phase_q <= `PH_RESET;
      halt_req_q <= 1'b0;
      mode_cap_q <= `MODE_SINGLE;
      halt_bit <= 1'b0;
    end else begin
      phase_q <= phase_d;
      if (!perst_n_s) begin
        // halt level and mode follow the pins only while reset is held
        halt_req_q <= halt_s;
        mode_cap_q <= mode_s;
        halt_bit <= halt_s;
      end else if (halt_bit_set && phase_q == `PH_HALT) begin
        // in the halt phase a set in the same cycle as a clear wins
        halt_bit <= 1'b1;
      end else if (halt_bit_clear) begin
        halt_bit <= 1'b0;
      end
    end
  end

  // ************************************************************
  // mode table
  // ************************************************************
  // one row per defined code, reserved codes share the default, so the table reads straight against the strap list
  reg valid_d;
  reg multi_d;
  reg eeprom_d;
  reg jump_valid_d;
  reg [1:0] jump_d;
  reg lowlat_d;
  reg disabled_d;
  reg i2c_d;

  always @* begin
    valid_d = !is_reserved(mode_cap_q);
    multi_d = 1'b0;
    eeprom_d = 1'b0;
    jump_valid_d = 1'b0;
    jump_d = `JUMP_ENTRY0;
    lowlat_d = 1'b0;
    disabled_d = 1'b0;
    i2c_d = 1'b0;
    case (mode_cap_q)
      `MODE_SINGLE: begin
        multi_d = 1'b0;
      end
      `MODE_SINGLE_EE: begin
        eeprom_d = 1'b1;
      end
      `MODE_SINGLE_JUMP0: begin
        eeprom_d = 1'b1;
        jump_valid_d = 1'b1;
        jump_d = `JUMP_ENTRY0;
      end
      `MODE_SINGLE_JUMP1: begin
        eeprom_d = 1'b1;
        jump_valid_d = 1'b1;
        jump_d = `JUMP_ENTRY1;
      end
      `MODE_LOWLAT: begin
        lowlat_d = 1'b1;
      end
      `MODE_LOWLAT_EE: begin
        lowlat_d = 1'b1;
        eeprom_d = 1'b1;
      end
      `MODE_MULTI_UNATT: begin
        multi_d = 1'b1;
      end
      `MODE_MULTI_UNATT_I2C: begin
        multi_d = 1'b1;
        i2c_d = 1'b1;
      end
      `MODE_MULTI_UNATT_EE: begin
        multi_d = 1'b1;
        eeprom_d = 1'b1;
      end
      `MODE_MULTI_DIS: begin
        multi_d = 1'b1;
        disabled_d = 1'b1;
      end
      `MODE_MULTI_DIS_I2C: begin
        multi_d = 1'b1;
        disabled_d = 1'b1;
        i2c_d = 1'b1;
      end
      `MODE_MULTI_DIS_EE: begin
        multi_d = 1'b1;
        disabled_d = 1'b1;
        eeprom_d = 1'b1;
      end
      default: begin
        // reserved codes keep every flag low, so nothing downstream acts on them
        valid_d = !is_reserved(mode_cap_q);
      end
    endcase
  end

  // ************************************************************
  // registered outputs
  // ************************************************************
  always @(posedge clk_sys) begin
    if (!resetn) begin
      core_reset_n <= 1'b0;
      quasi_reset <= 1'b0;
      smbus_master_en <= 1'b0;
      smbus_slave_en <= 1'b0;
      smbus_reg_access_en <= 1'b0;
      mode_q <= `MODE_SINGLE;
      mode_valid <= 1'b0;
      multi_partition <= 1'b0;
      eeprom_init <= 1'b0;
      eeprom_jump <= 2'h0;
      jump_valid <= 1'b0;
      reduced_latency <= 1'b0;
      ports_disabled <= 1'b0;
      i2c_reset <= 1'b0;
    end else begin
      core_reset_n <= (phase_d == `PH_RUN);
      quasi_reset <= (phase_d == `PH_HALT);
      smbus_master_en <= (phase_d != `PH_RESET);
      smbus_slave_en <= (phase_d != `PH_RESET);
      smbus_reg_access_en <= (phase_d != `PH_RESET);
      // mode outputs are held, so late pin changes cannot disturb a running switch
      mode_q <= mode_cap_q;
      mode_valid <= valid_d;
      multi_partition <= multi_d;
      eeprom_init <= eeprom_d;
      jump_valid <= jump_valid_d;
      eeprom_jump <= jump_d;
      reduced_latency <= lowlat_d;
      ports_disabled <= disabled_d;
      i2c_reset <= i2c_d;
    end
  end
endmodule

/* File: testbench/switch_board_model.sv */
// board reset logic and smbus master stand-in
// assumes the bench calls its tasks from the clk_sys domain
`timescale 1ns/1ps
module switch_board_model (
  input wire clk_sys,
  output reg fundamental_reset_n = 1'b0,
  output reg reset_halt = 1'b0,
  output reg [3:0] switch_mode_select = 4'h0,
  output reg halt_bit_clear = 1'b0,
  output reg halt_bit_set = 1'b0
);
  task set_and_clear;
    begin
      halt_bit_set = 1'b1; // set and clear land together, set must win
      halt_bit_clear = 1'b1;
      @(negedge clk_sys);
      halt_bit_set = 1'b0;
      halt_bit_clear = 1'b0;
    end
  endtask
  task boot(input [3:0] m, input h);
    begin
      @(negedge clk_sys);
      fundamental_reset_n = 1'b0;
      switch_mode_select = m;
      reset_halt = h;
      repeat (8) @(negedge clk_sys);
      fundamental_reset_n = 1'b1; // mode pins stay put from here
      repeat (8) @(negedge clk_sys);
    end
  endtask
  task clear_halt;
    begin
      halt_bit_clear = 1'b1; // master write clears the halt bit
      @(negedge clk_sys);
      halt_bit_clear = 1'b0;
    end
  endtask
endmodule

/* File: testbench/switch_reset_mode_properties.sv */
// timing and decode checks on the reset front end
// assumes binding to switch_reset_mode, one clock domain
`timescale 1ns/1ps
module switch_reset_mode_properties (
  input wire clk_sys, resetn, fundamental_reset_n, halt_bit_clear, halt_bit_set,
  input wire core_reset_n, quasi_reset, smbus_master_en, smbus_slave_en,
  input wire smbus_reg_access_en, mode_valid, multi_partition, eeprom_init,
  input wire jump_valid, reduced_latency,
  input wire [1:0] eeprom_jump,
  input wire [3:0] mode_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_reset_clears: assert property (!fundamental_reset_n [*6] |-> !core_reset_n && !quasi_reset)
    else $error("outputs live during reset");
  a_halt_core_off: assert property (quasi_reset |-> !core_reset_n && smbus_master_en
    && smbus_slave_en) else $error("halt phase wrong");
  a_halt_access: assert property (quasi_reset |-> smbus_reg_access_en)
    else $error("no register access in halt");
  a_clear_runs: assert property (quasi_reset && halt_bit_clear && !halt_bit_set |->
    ##2 core_reset_n && !quasi_reset) else $error("halt clear not honoured");
  a_mode_held: assert property (core_reset_n && $past(core_reset_n) |-> $stable(mode_q))
    else $error("mode changed while running");
  a_single_dec: assert property (core_reset_n && mode_q[3:1] == 3'h0 |-> mode_valid
    && !multi_partition && eeprom_init == mode_q[0]) else $error("single decode");
  a_jump_dec: assert property (core_reset_n && mode_q[3:1] == 3'h1 |-> jump_valid
    && eeprom_jump == {1'b0, mode_q[0]}) else $error("jump decode");
  a_rsvd_dec: assert property (core_reset_n && mode_q[3:2] == 2'h1 |-> !mode_valid
    && !multi_partition && !eeprom_init) else $error("reserved decode");
  a_lowlat_dec: assert property (core_reset_n && mode_q[3:1] == 3'h4 |-> reduced_latency
    && !multi_partition) else $error("low latency decode");
  a_multi_dec: assert property (core_reset_n && mode_q > 4'h9 |-> multi_partition)
    else $error("multi decode");
endmodule
bind switch_reset_mode switch_reset_mode_properties u_props (.clk_sys, .resetn,
  .fundamental_reset_n, .halt_bit_clear, .halt_bit_set, .core_reset_n, .quasi_reset,
  .smbus_master_en, .smbus_slave_en, .smbus_reg_access_en, .mode_valid,
  .multi_partition, .eeprom_init, .jump_valid, .reduced_latency, .eeprom_jump, .mode_q);

/* File: testbench/switch_reset_mode_test.sv */
// self-checking bench for the reset and mode front end
// assumes switch_board_model drives the pins and the smbus clear pulse
`timescale 1ns/1ps
module switch_reset_mode_test;
  reg clk_sys = 1'b0;
  reg resetn = 1'b0;
  wire frn, rh, hc, hs, cr, qr, sme, sse, sra, hb, mv, mp, ee, jv, rl, pd, i2;
  wire [3:0] sms, mq;
  wire [1:0] ej;
  integer fail_count = 0;
  integer samples_checked = 0;
  integer i;
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  switch_board_model u_switch_board_model (.clk_sys(clk_sys), .fundamental_reset_n(frn),
    .reset_halt(rh), .switch_mode_select(sms), .halt_bit_clear(hc), .halt_bit_set(hs));
  switch_reset_mode u_switch_reset_mode (.clk_sys(clk_sys), .resetn(resetn),
    .fundamental_reset_n(frn), .reset_halt(rh), .switch_mode_select(sms),
    .halt_bit_set(hs), .halt_bit_clear(hc), .core_reset_n(cr), .quasi_reset(qr),
    .smbus_master_en(sme), .smbus_slave_en(sse), .smbus_reg_access_en(sra), .halt_bit(hb),
    .mode_q(mq), .mode_valid(mv), .multi_partition(mp), .eeprom_init(ee), .eeprom_jump(ej),
    .jump_valid(jv), .reduced_latency(rl), .ports_disabled(pd), .i2c_reset(i2));
  task chk(input [8*8:1] name, input [7:0] exp, input [7:0] got);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("Error %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // packed expectation: valid, multi, eeprom, lowlat, disabled, i2c, jump valid, jump entry
  function [7:0] expd(input [3:0] m);
    expd = {m[3:2] != 2'h1, m > 4'h9, m == 1 || m == 2 || m == 3 || m == 9 || m == 12 ||
      m == 15, m[3:1] == 3'h4, m > 4'hC, m == 11 || m == 14, m[3:1] == 3'h1, m == 3};
  endfunction
  task test_modes;
    begin
      for (i = 0; i < 16; i = i + 1) begin
        u_switch_board_model.boot(i, 1'b0);
        chk("decode", expd(i), {mv, mp, ee, rl, pd, i2, jv, jv & ej[0]});
        chk("mode", i, {4'h0, mq});
      end
      $display("test_modes done");
    end
  endtask
  task test_halt;
    begin
      u_switch_board_model.boot(4'h1, 1'b1);
      chk("halt", 8'h0F, {cr, qr, sme, sse, sra});
      chk("hbit", 8'h01, {7'h00, hb});
      u_switch_board_model.set_and_clear;
      repeat (3) @(negedge clk_sys);
      chk("setwins", 8'h03, {6'h00, qr, hb});
      u_switch_board_model.clear_halt;
      repeat (3) @(negedge clk_sys);
      chk("run", 8'h17, {cr, qr, sme, sse, sra});
      chk("hbit", 8'h00, {7'h00, hb});
      u_switch_board_model.switch_mode_select = 4'h8;
      repeat (8) @(negedge clk_sys);
      chk("held", 8'h01, {rl, mq});
      u_switch_board_model.fundamental_reset_n = 1'b0;
      repeat (7) @(negedge clk_sys);
      chk("reset", 8'h00, {cr, qr, sme, sse, sra});
      $display("test_halt done");
    end
  endtask
  initial begin
    #20000;
    fail_count = fail_count + 1;
    report_and_stop;
  end
  initial begin
    repeat (3) @(negedge clk_sys);
    resetn = 1'b1;
    test_modes;
    test_halt;
    report_and_stop;
  end
endmodule
